// File: hw/adc_ctrl_pkg.sv
// Package: register map, field layout and shared types for the converter control block
package adc_ctrl_pkg;

  // Special function register addresses
  localparam logic [7:0] REF_CTRL_ADDR  = 8'h00_D1;
  localparam logic [7:0] CONV_CTRL_ADDR = 8'h00_E8;

  // Reset values
  localparam logic [7:0] REF_CTRL_RESET  = 8'h00_18;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00_00;

  // Converter control field positions
  localparam int CC_ENABLE_BIT = 7;
  localparam int CC_BURST_BIT  = 6;
  localparam int CC_DONE_BIT   = 5;
  localparam int CC_BUSY_BIT   = 4;
  localparam int CC_WIN_BIT    = 3;
  localparam int CC_SRC_LSB    = 0;
  localparam int CC_SRC_W      = 3;

  // Reference control field positions
  localparam int RC_LEVEL_BIT  = 7;
  localparam int RC_GND_BIT    = 5;
  localparam int RC_SEL_LSB    = 3;
  localparam int RC_SEL_W      = 2;
  localparam int RC_TEMP_BIT   = 2;
  // Writable bits of the reference register; bits 6 and 1:0 are read-only zero
  localparam logic [7:0] REF_CTRL_WMASK = 8'h00_BC;

  // Start-of-conversion sources
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0   = 3'h1;
  localparam logic [2:0] SRC_TIMER2   = 3'h2;
  localparam logic [2:0] SRC_TIMER3   = 3'h3;
  localparam logic [2:0] SRC_EXTERNAL = 3'h4;

  // Reference choices
  localparam logic [1:0] REF_PIN      = 2'h0;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;
  localparam logic [1:0] REF_CORE_1V8 = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;

  // Bus access from the processor
  typedef struct packed {
    logic       wr;       // Byte write strobe
    logic       bit_wr;   // Single bit write strobe
    logic [7:0] addr;     // Register address
    logic [2:0] bit_idx;  // Bit number for bit writes
    logic [7:0] wdata;    // Write data; bit writes use wdata[0]
  } sfr_req_type;

  // Analog-side steering
  typedef struct packed {
    logic       powered;    // Converter out of shutdown
    logic       burst;      // Burst mode selected
    logic       level_hi;   // Internal reference at the higher level
    logic       analog_ground_pin_sel;   // Ground from analog ground pin
    logic [1:0] ref_sel;    // Reference source
    logic       temp_on;    // Temperature sensor on
  } analog_ctrl_type;

endpackage : adc_ctrl_pkg

// File: hw/adc_control.sv
// Converter control and reference select registers with start-source logic
`timescale 1ns/1ps

// Overview of operation
// - Enable bit 7 zero keeps converter shut down; one makes it active.
// - Control bit 6 selects burst mode.
// - Done flag bit 5 set at conversion or burst end; only software clears.
// - With source 000, writing busy bit 4 as one starts a conversion.
// - Window flag bit 3 set when result falls inside window; software clears.
// - Source codes 001, 010, 011 start on timer 0, 2, 3 overflow.
// - Source code 100 starts on external start input rising edge.
// - Control register at address 0xE8, bit-addressable, resets to zero.
// - Reference level bit 7 picks 1.65 V when zero, 2.4 V when one.
// - Ground select bit 5 picks ground pin or analog ground pin.
// - Reference select bits 4:3 choose pin, supply, 1.8 V, internal; reset 11.
// - Reference bit 2 turns the temperature sensor on.
module adc_control
  import adc_ctrl_pkg::*;
(
  input  wire logic            ref_clk,        // System clock, 40 MHz
  input  wire logic            rst,            // Synchronous reset, active high
  input  wire sfr_req_type     sfr_req,        // Register access from the processor
  output logic [7:0]           conv_ctrl_rd,   // Converter control register value
  output logic [7:0]           ref_ctrl_rd,    // Reference control register value
  input  wire logic            timer0_ovf,     // Timer 0 overflow pulse
  input  wire logic            timer2_ovf,     // Timer 2 overflow pulse
  input  wire logic            timer3_ovf,     // Timer 3 overflow pulse
  input  wire logic            external_convert_start, // External start level
  input  wire logic            conv_finished,  // Single conversion finished pulse
  input  wire logic            burst_finished, // Whole burst finished pulse
  input  wire logic            window_hit,     // Result lies within window, pulse
  output logic                 conv_start,     // Start one conversion, pulse
  output analog_ctrl_type      analog_ctrl     // Steering of the analog side
);

  // ==========================================================================
  // Registers
  logic [7:0]      cc_r;
  logic [7:0]      cc_nxt;
  logic [7:0]      rc_r;
  logic [7:0]      rc_nxt;
  logic            ext_prev_r;
  logic            conv_start_r;
  analog_ctrl_type analog_r;

  // ==========================================================================
  // Address decode and write data
  wire logic cc_sel     = (sfr_req.addr == CONV_CTRL_ADDR);
  wire logic rc_sel     = (sfr_req.addr == REF_CTRL_ADDR);
  wire logic cc_byte_wr = sfr_req.wr & cc_sel;
  wire logic cc_bit_wr  = sfr_req.bit_wr & cc_sel;
  wire logic rc_wr      = sfr_req.wr & rc_sel;

  // Bit writes merge one bit into the current value, as a read-modify-write would
  logic [7:0] bit_mask;
  assign bit_mask = 8'h00_01 << sfr_req.bit_idx;
  wire logic [7:0] cc_wdata = cc_byte_wr ? sfr_req.wdata :
                              ((cc_r & ~bit_mask) | ({8{sfr_req.wdata[0]}} & bit_mask));
  wire logic cc_any_wr = cc_byte_wr | cc_bit_wr;
  wire logic cc_bit_written [8];
  for (genvar i = 0; i < 8; i++) begin : g_bitwr
    assign cc_bit_written[i] = cc_byte_wr | (cc_bit_wr & (sfr_req.bit_idx == 3'(i)));
  end

  // ==========================================================================
  // Start trigger selection
  wire logic enabled    = cc_r[CC_ENABLE_BIT];
  wire logic [2:0] src  = cc_r[CC_SRC_LSB +: CC_SRC_W];
  wire logic ext_rise   = external_convert_start & ~ext_prev_r;
  wire logic sw_start   = cc_bit_written[CC_BUSY_BIT] & cc_wdata[CC_BUSY_BIT];
  logic trig;
  always_comb begin
    case (src)
      SRC_SOFTWARE: trig = sw_start;
      SRC_TIMER0:   trig = timer0_ovf;
      SRC_TIMER2:   trig = timer2_ovf;
      SRC_TIMER3:   trig = timer3_ovf;
      SRC_EXTERNAL: trig = ext_rise;
      default:      trig = 1'b0;  // Reserved codes never start anything
    endcase
  end
  // Disabled converter ignores every trigger
  wire logic start_now  = trig & enabled;
  wire logic busy       = cc_r[CC_BUSY_BIT];
  wire logic done_evt   = enabled & busy &
                          (cc_r[CC_BURST_BIT] ? burst_finished : conv_finished);
  wire logic win_evt    = enabled & window_hit;

  // ==========================================================================
  // Next value of the converter control register
  always_comb begin
    cc_nxt = cc_any_wr ? cc_wdata : cc_r;
    // Software never sets busy directly; hardware owns it
    cc_nxt[CC_BUSY_BIT] = busy;
    if (done_evt) begin
      cc_nxt[CC_BUSY_BIT] = 1'b0;
    end
    if (start_now) begin
      cc_nxt[CC_BUSY_BIT] = 1'b1;
    end
    // Flags: a hardware set wins over a software clear in the same cycle
    if (done_evt) begin
      cc_nxt[CC_DONE_BIT] = 1'b1;
    end
    if (win_evt) begin
      cc_nxt[CC_WIN_BIT] = 1'b1;
    end
    // Disabling drops any conversion in flight
    if (!cc_nxt[CC_ENABLE_BIT]) begin
      cc_nxt[CC_BUSY_BIT] = 1'b0;
    end
  end

  // Reference register: reserved bits stay zero whatever is written
  assign rc_nxt = rc_wr ? (sfr_req.wdata & REF_CTRL_WMASK) : rc_r;

  // ==========================================================================
  // State update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cc_r <= CONV_CTRL_RESET;
      rc_r <= REF_CTRL_RESET;
      ext_prev_r <= 1'b0;
    end else begin
      cc_r <= cc_nxt;
      rc_r <= rc_nxt;
      ext_prev_r <= external_convert_start;
    end
  end

  // Outputs all from flip-flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_start_r <= 1'b0;
      // Steering shows the register reset values at once, so the reference is sound in reset
      analog_r.powered  <= 1'b0;
      analog_r.burst    <= 1'b0;
      analog_r.level_hi <= REF_CTRL_RESET[RC_LEVEL_BIT];
      analog_r.analog_ground_pin_sel <= REF_CTRL_RESET[RC_GND_BIT];
      analog_r.ref_sel  <= REF_CTRL_RESET[RC_SEL_LSB +: RC_SEL_W];
      analog_r.temp_on  <= REF_CTRL_RESET[RC_TEMP_BIT];
    end else begin
      conv_start_r      <= start_now;
      analog_r.powered  <= cc_nxt[CC_ENABLE_BIT];
      analog_r.burst    <= cc_nxt[CC_BURST_BIT];
      analog_r.level_hi <= rc_nxt[RC_LEVEL_BIT];
      analog_r.analog_ground_pin_sel <= rc_nxt[RC_GND_BIT];
      analog_r.ref_sel  <= rc_nxt[RC_SEL_LSB +: RC_SEL_W];
      analog_r.temp_on  <= rc_nxt[RC_TEMP_BIT];
    end
  end

  assign conv_ctrl_rd = cc_r;
  assign ref_ctrl_rd  = rc_r;
  assign conv_start   = conv_start_r;
  assign analog_ctrl  = analog_r;

  // ==========================================================================
  // Assertions
  a_shutdown_follows: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (analog_ctrl.powered == cc_r[CC_ENABLE_BIT]))
    else $error("Shutdown state does not follow enable bit");
  a_burst_follows: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (analog_ctrl.burst == cc_r[CC_BURST_BIT]))
    else $error("Burst state does not follow control bit");
  a_done_sets: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && busy && !cc_r[CC_BURST_BIT] && conv_finished) |=> cc_r[CC_DONE_BIT])
    else $error("Done flag not set after conversion");
  a_done_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (cc_r[CC_DONE_BIT] && !cc_any_wr) |=> cc_r[CC_DONE_BIT])
    else $error("Done flag cleared without a write");
  a_sw_start: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_SOFTWARE && sw_start) |=> (conv_start && busy))
    else $error("Software start did not begin a conversion");
  a_win_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (win_evt || (cc_r[CC_WIN_BIT] && !cc_any_wr)) |=> cc_r[CC_WIN_BIT])
    else $error("Window flag lost");
  a_timer_start: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_TIMER2 && timer2_ovf) |=> conv_start)
    else $error("Timer 2 overflow did not start a conversion");
  a_ext_edge: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_EXTERNAL && $rose(external_convert_start)) |=> conv_start)
    else $error("External rising edge did not start a conversion");
  a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (!enabled) |=> !conv_start)
    else $error("Conversion started while disabled");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_rd & ~REF_CTRL_WMASK) == 8'h00_00)
    else $error("Reserved reference bits not zero");
  a_busy_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (done_evt && !start_now) |=> !busy)
    else $error("Busy still set after conversion end");
  a_level_follows: assert property (@(posedge ref_clk) disable iff (rst)
    rc_wr |=> (analog_ctrl.level_hi == $past(sfr_req.wdata[RC_LEVEL_BIT])))
    else $error("Reference level not applied");

  // Timer 0 overflow starts a conversion when selected
  a_timer0_start: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_TIMER0 && timer0_ovf) |=> conv_start)
    else $error("Timer 0 overflow did not start a conversion");

  // Timer 3 overflow starts a conversion when selected
  a_timer3_start: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_TIMER3 && timer3_ovf) |=> conv_start)
    else $error("Timer 3 overflow did not start a conversion");

  // Burst end sets the done flag in burst mode
  a_burst_done: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && busy && cc_r[CC_BURST_BIT] && burst_finished) |=> cc_r[CC_DONE_BIT])
    else $error("Done flag not set after burst");

  // In burst mode a single finish must not raise the done flag
  a_burst_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (cc_r[CC_BURST_BIT] && !cc_r[CC_DONE_BIT] && !burst_finished && !cc_any_wr)
      |=> !cc_r[CC_DONE_BIT])
    else $error("Done flag set before burst end");

  // Disabled converter leaves the window flag alone
  a_win_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (!enabled && !cc_r[CC_WIN_BIT] && !cc_any_wr) |=> !cc_r[CC_WIN_BIT])
    else $error("Window flag set while disabled");

  // Disabled converter leaves the done flag alone
  a_done_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (!enabled && !cc_r[CC_DONE_BIT] && !cc_any_wr) |=> !cc_r[CC_DONE_BIT])
    else $error("Done flag set while disabled");

  // Reserved source codes never start anything
  a_reserved_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (src > SRC_EXTERNAL) |=> !conv_start)
    else $error("Reserved source code started a conversion");

  // A steady external level must not start; only the rising edge counts
  a_ext_level: assert property (@(posedge ref_clk) disable iff (rst)
    (src == SRC_EXTERNAL && !$rose(external_convert_start)) |=> !conv_start)
    else $error("External start without rising edge");

  // Busy rises with every accepted start
  a_busy_sets: assert property (@(posedge ref_clk) disable iff (rst)
    start_now |=> busy)
    else $error("Busy not set at conversion start");

  // Busy stays up until the finish arrives
  a_busy_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && !done_evt && !cc_any_wr) |=> busy)
    else $error("Busy dropped before conversion end");

  // Busy never rises on its own
  a_busy_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (!busy && !start_now) |=> !busy)
    else $error("Busy set without a start");

  // Reference select follows a write to the reference register
  a_sel_follows: assert property (@(posedge ref_clk) disable iff (rst)
    rc_wr |=> (analog_ctrl.ref_sel == $past(sfr_req.wdata[RC_SEL_LSB +: RC_SEL_W])))
    else $error("Reference select not applied");

  // Ground selection follows a write to the reference register
  a_gnd_follows: assert property (@(posedge ref_clk) disable iff (rst)
    rc_wr |=> (analog_ctrl.analog_ground_pin_sel == $past(sfr_req.wdata[RC_GND_BIT])))
    else $error("Ground select not applied");

  // Temperature sensor enable follows a write to the reference register
  a_temp_follows: assert property (@(posedge ref_clk) disable iff (rst)
    rc_wr |=> (analog_ctrl.temp_on == $past(sfr_req.wdata[RC_TEMP_BIT])))
    else $error("Temperature sensor enable not applied");

  // Control register holds when nothing writes it and no event lands
  a_cc_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!cc_any_wr && !start_now && !done_evt && !win_evt) |=> $stable(conv_ctrl_rd))
    else $error("Control register changed without cause");

  // Reference register holds when nothing writes it
  a_rc_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !rc_wr |=> $stable(ref_ctrl_rd))
    else $error("Reference register changed without a write");

  // Shut-down converter is never busy
  a_shutdown_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !analog_ctrl.powered |-> !busy)
    else $error("Busy while shut down");

  // A bit write of one to busy starts a conversion with software source
  a_bit_start: assert property (@(posedge ref_clk) disable iff (rst)
    (enabled && src == SRC_SOFTWARE && cc_bit_wr && sfr_req.bit_idx == 3'(CC_BUSY_BIT)
      && sfr_req.wdata[0]) |=> conv_start)
    else $error("Bit write of busy did not start a conversion");

endmodule : adc_control

// File: test/test_adc_control.sv
// Self-checking testbench for the converter control and reference select block
`timescale 1ns/1ps
module test_adc_control
  import adc_ctrl_pkg::*;
;
  // ==========================================================
  // Signals
  logic            ref_clk   = 1'b0;  // 40 MHz system clock
  logic            rst       = 1'b1;  // Synchronous reset
  sfr_req_type     req;               // Register writes
  logic [6:0]      ev;                // Triggers and finish pulses
  logic [7:0]      cc_rd;             // Converter control readback
  logic [7:0]      rc_rd;             // Reference control readback
  logic            conv_start;        // Start pulse
  analog_ctrl_type actl;              // Analog steering
  logic [7:0]      d;                 // Random data
  logic [7:0]      a;                 // Random address
  logic [2:0]      s;                 // Source code under test
  logic            e;                 // Enable under test
  logic            x;                 // Expected start
  int              error_cnt = 0;
  int              n_tests   = 0;
  int              cyc_cnt   = 0;

  always #12.5 ref_clk = ~ref_clk;

  adc_control i_adc_control (
    .ref_clk(ref_clk), .rst(rst), .sfr_req(req), .conv_ctrl_rd(cc_rd), .ref_ctrl_rd(rc_rd),
    .timer0_ovf(ev[0]), .timer2_ovf(ev[1]), .timer3_ovf(ev[2]),
    .external_convert_start(ev[3]), .conv_finished(ev[4]), .burst_finished(ev[5]),
    .window_hit(ev[6]), .conv_start(conv_start), .analog_ctrl(actl));

  // ==========================================================
  // Helpers; every task starts and ends at a falling edge so outputs are settled
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt, input logic bw,
                    input logic [2:0] idx);
    req = '{wr: ~bw, bit_wr: bw, addr: ad, bit_idx: idx, wdata: dt};
    @(posedge ref_clk);
    // Strobe drops on the taking edge, so a following call never reassigns it in one step
    req.wr     <= 1'b0;
    req.bit_wr <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  // One-cycle pulse; low before and after, so the external line shows one rising edge
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(posedge ref_clk);
    ev[k] <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse

  // Trigger t: 0 timer 0, 1 timer 2, 2 timer 3, 3 external start
  function automatic logic exp_start(input logic en, input logic [2:0] src, input int t);
    return en && (src == 3'(t + 1));
  endfunction : exp_start

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    req = '0;
    ev  = '0;
    void'($urandom(32'h81d8_95fb));
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check(cc_rd, 8'h00_00);
    check(rc_rd, 8'h00_18);
    check(8'(actl.ref_sel), 8'(REF_INTERNAL));
    check(8'(actl.powered), 8'h00_00);
    check(8'(conv_start), 8'h00_00);
    $display("test reset done");
    // Reference register: all ones and all zeros first, then random bytes
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h00_FF : (i == 1) ? 8'h00_00 : 8'($urandom);
      wr(REF_CTRL_ADDR, d, 1'b0, 3'h0);
      check(rc_rd, d & 8'h00_BC);
      check(8'(actl.level_hi), 8'(d[7]));
      check(8'(actl.analog_ground_pin_sel), 8'(d[5]));
      check(8'(actl.ref_sel), 8'(d[4:3]));
      check(8'(actl.temp_on), 8'(d[2]));
    end
    // A write elsewhere in the space must leave both registers alone
    a = 8'($urandom);
    if (a == REF_CTRL_ADDR || a == CONV_CTRL_ADDR) a = a ^ 8'h00_01;
    wr(a, 8'h00_FF, 1'b0, 3'h0);
    check(rc_rd, d & 8'h00_BC);
    check(cc_rd, 8'h00_00);
    $display("test reference done");
    // Every source code against every trigger, disabled and enabled
    for (int en = 0; en < 2; en++) begin
      for (int sc = 0; sc < 8; sc++) begin
        for (int t = 0; t < 4; t++) begin
          e = en[0];
          s = sc[2:0];
          x = exp_start(e, s, t);
          wr(CONV_CTRL_ADDR, 8'h00_00, 1'b0, 3'h0);
          wr(CONV_CTRL_ADDR, {e, 4'h0, s}, 1'b0, 3'h0);
          check(cc_rd, {e, 4'h0, s});
          check(8'(actl.powered), 8'(e));
          pulse(t);
          check(8'(conv_start), 8'(x));
          check(8'(cc_rd[4]), 8'(x));
        end
      end
    end
    $display("test sources done");
    // Software start only counts when the stored source is already 000
    wr(CONV_CTRL_ADDR, 8'h00_81, 1'b0, 3'h0);
    wr(CONV_CTRL_ADDR, 8'h00_91, 1'b0, 3'h0);
    check(8'(conv_start), 8'h00_00);
    wr(CONV_CTRL_ADDR, 8'h00_80, 1'b0, 3'h0);
    wr(CONV_CTRL_ADDR, 8'h00_90, 1'b0, 3'h0);
    check(8'(conv_start), 8'h00_01);
    check(cc_rd, 8'h00_90);
    pulse(4);
    check(cc_rd, 8'h00_A0);
    wr(CONV_CTRL_ADDR, 8'h00_00, 1'b1, 3'h5);
    check(cc_rd, 8'h00_80);
    $display("test software start done");
    // Burst: a single finish does not end it, the burst finish does
    wr(CONV_CTRL_ADDR, 8'h00_D0, 1'b0, 3'h0);
    check(8'(conv_start), 8'h00_01);
    check(8'(actl.burst), 8'h00_01);
    pulse(4);
    check(cc_rd, 8'h00_D0);
    pulse(5);
    check(cc_rd, 8'h00_E0);
    pulse(6);
    check(cc_rd, 8'h00_E8);
    wr(CONV_CTRL_ADDR, 8'h00_80, 1'b0, 3'h0);
    check(cc_rd, 8'h00_80);
    // Disabled converter ignores window and finish pulses
    wr(CONV_CTRL_ADDR, 8'h00_00, 1'b0, 3'h0);
    pulse(6);
    pulse(4);
    check(cc_rd, 8'h00_00);
    $display("test burst and flags done");
    // Bit-write start, then finish and window in the same cycle as a clear: set wins
    wr(CONV_CTRL_ADDR, 8'h00_80, 1'b0, 3'h0);
    wr(CONV_CTRL_ADDR, 8'h00_01, 1'b1, 3'h4);
    check(8'(conv_start), 8'h00_01);
    check(cc_rd, 8'h00_90);
    ev = 7'h50;
    wr(CONV_CTRL_ADDR, 8'h00_00, 1'b1, 3'h5);
    ev = '0;
    check(cc_rd, 8'h00_A8);
    $display("test set wins done");
    // Reset in mid-run restores both registers and the steering
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(8'(actl.ref_sel), 8'(REF_INTERNAL));
    rst = 1'b0;
    @(negedge ref_clk);
    check(cc_rd, 8'h00_00);
    check(rc_rd, 8'h00_18);
    check(8'(actl.powered), 8'h00_00);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : test_adc_control
